// ---- fantc_bank.v ----
// fantc register bank: readings, tach configuration, test registers, alert pin
//
// Function
// R1 - 12 V reading low two bits appear in low-bits register bits 1:0.
// R2 - first remote temperature low two bits appear in bits 3:2.
// R3 - local temperature low two bits appear in bits 5:4.
// R4 - second remote temperature low two bits appear in bits 7:6.
// R5 - reading low bits freezes them and high bytes until each high byte is read.
// R6 - config bit 0 picks alert output on shared pin, else fan drive two.
// R7 - config bit 3 speeds tach measurement from once a second to every 250 ms.
// R8 - config bits 4 to 7 enable continuous measurement on tach inputs one to four.
// R9 - config register resets to zero: fan drive, slow rate, no continuous mode.
// R10 - after lock is set, config and both test registers ignore writes.
// R11 - each fan's 2-bit field selects one to four pulses counted.
// R12 - pulse-count register resets to 0x55; fan one in bits 1:0, four in 7:6.
// R13 - host leaves test registers alone; they reset to zero.
// R14 - writes to read-only registers or fields are silently ignored.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

`include "fantc_regs.vh"

module fantc_bank #(
	parameter SLOW_CYCLES = `FANTC_SLOW_PERIOD_MS * `FANTC_CLK_KHZ,
	parameter FAST_CYCLES = `FANTC_FAST_PERIOD_MS * `FANTC_CLK_KHZ
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire [9:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	output wire [31:0] o_avs_readdata,
	output wire o_avs_waitrequest,
	input wire [9:0] i_meas_12v,
	input wire [9:0] i_meas_remote1,
	input wire [9:0] i_meas_local,
	input wire [9:0] i_meas_remote2,
	input wire i_out_of_limit,
	input wire i_fan_drive_2,
	output wire o_shared_pin_out,
	output wire o_shared_pin_oe_n,
	output wire o_measure_tick,
	output wire o_fast_mode,
	output wire [3:0] o_continuous_tach,
	output wire [2:0] o_pulse_count_fan_a,
	output wire [2:0] o_pulse_count_fan_b,
	output wire [2:0] o_pulse_count_fan_c,
	output wire [2:0] o_pulse_count_fan_d,
	output wire o_lock,
	output wire o_irq
);
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_ACK = 2'b10;
	// last count of each period; 27 bits hold a full second at the core clock
	localparam [31:0] SLOW_LAST_W = SLOW_CYCLES - 1;
	localparam [31:0] FAST_LAST_W = FAST_CYCLES - 1;
	localparam [26:0] SLOW_LAST = SLOW_LAST_W[26:0];
	localparam [26:0] FAST_LAST = FAST_LAST_W[26:0];
	localparam [7:0] PULSE_CNT_RST = `FANTC_PULSE_CNT_RST;

	// register index match; the two low address bits must be zero
	function sel;
		input [9:0] addr;
		input [7:0] idx;
		begin
			sel = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
		end
	endfunction

	// 2-bit field to number of pulses counted
	function [2:0] pulses;
		input [1:0] code;
		begin
			pulses = {1'b0, code} + 3'h1; // R11
		end
	endfunction

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [31:0] rdata_ff;
	reg [7:0] nxt_rdata;
	reg [7:0] config3_ff;
	reg [7:0] pulse_cnt_ff;
	reg [7:0] test1_ff;
	reg [7:0] test2_ff;
	reg lock_ff;
	reg [2:0] int_status_ff;
	reg [2:0] int_enable_ff;
	reg [26:0] tick_cnt_ff;
	reg tick_ff;
	reg fast_prev_ff;

	wire req;
	wire capture;
	wire commit;
	wire wr_commit;
	wire low_read;
	wire [3:0] hi_read;
	wire [39:0] live;
	wire [39:0] snap;
	wire snap_release;
	wire [9:0] snap_12v;
	wire [9:0] snap_remote1;
	wire [9:0] snap_local;
	wire [9:0] snap_remote2;
	wire [7:0] low_bits;
	wire [7:0] wbyte;
	wire [26:0] tick_last;
	wire [2:0] int_events;
	wire [2:0] int_clear;
	wire alert_active;
	wire [11:0] pulse_counts;
	// write strobes, one per writable register
	wire wr_config3;
	wire wr_pulse_cnt;
	wire wr_test1;
	wire wr_test2;
	wire wr_lock;
	wire wr_int_enable;
	wire wr_int_clear;

	// bus handshake: every access takes one wait cycle, then completes
	assign req = i_avs_read | i_avs_write;
	assign capture = req & state_ff[0];
	assign commit = req & state_ff[1];
	assign wr_commit = commit & i_avs_write & i_avs_byteenable[0];
	assign o_avs_waitrequest = req & ~state_ff[1];
	assign o_avs_readdata = rdata_ff;
	assign wbyte = i_avs_writedata[7:0];

	always @* begin
		case (state_ff)
			ST_IDLE: nxt_state = req ? ST_ACK : ST_IDLE;
			ST_ACK: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	// one-hot state; an illegal code falls back to idle
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// side effects of reads happen once, at the capture edge
	assign low_read = capture & i_avs_read & sel(i_avs_address, `FANTC_IDX_LOW_BITS);
	assign hi_read[0] = capture & i_avs_read & sel(i_avs_address, `FANTC_IDX_HI_12V);
	assign hi_read[1] = capture & i_avs_read & sel(i_avs_address, `FANTC_IDX_HI_REMOTE1);
	assign hi_read[2] = capture & i_avs_read & sel(i_avs_address, `FANTC_IDX_HI_LOCAL);
	assign hi_read[3] = capture & i_avs_read & sel(i_avs_address, `FANTC_IDX_HI_REMOTE2);

	assign live = {i_meas_remote2, i_meas_local, i_meas_remote1, i_meas_12v};

	// release pulse feeds the status register; the freeze level is not needed here
	fantc_snap u_snap (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_live(live),
		.i_low_read(low_read),
		.i_hi_read(hi_read),
		.o_snap(snap),
		.o_frozen(),
		.o_release(snap_release)
	);

	assign snap_12v = snap[9:0];
	assign snap_remote1 = snap[19:10];
	assign snap_local = snap[29:20];
	assign snap_remote2 = snap[39:30];

	assign low_bits[`FANTC_LOW_12V_LSB +: 2] = snap_12v[1:0]; // R1
	assign low_bits[`FANTC_LOW_REMOTE1_LSB +: 2] = snap_remote1[1:0]; // R2
	assign low_bits[`FANTC_LOW_LOCAL_LSB +: 2] = snap_local[1:0]; // R3
	assign low_bits[`FANTC_LOW_REMOTE2_LSB +: 2] = snap_remote2[1:0]; // R4

	// read mux; unmapped and write-only indices read as zero
	always @* begin
		nxt_rdata = 8'h00;
		if (sel(i_avs_address, `FANTC_IDX_LOW_BITS)) begin
			nxt_rdata = low_bits;
		end else if (sel(i_avs_address, `FANTC_IDX_CONFIG3)) begin
			nxt_rdata = config3_ff;
		end else if (sel(i_avs_address, `FANTC_IDX_PULSE_CNT)) begin
			nxt_rdata = pulse_cnt_ff;
		end else if (sel(i_avs_address, `FANTC_IDX_TEST_1)) begin
			nxt_rdata = test1_ff;
		end else if (sel(i_avs_address, `FANTC_IDX_TEST_2)) begin
			nxt_rdata = test2_ff;
		end else if (sel(i_avs_address, `FANTC_IDX_HI_12V)) begin
			nxt_rdata = snap_12v[9:2];
		end else if (sel(i_avs_address, `FANTC_IDX_HI_REMOTE1)) begin
			nxt_rdata = snap_remote1[9:2];
		end else if (sel(i_avs_address, `FANTC_IDX_HI_LOCAL)) begin
			nxt_rdata = snap_local[9:2];
		end else if (sel(i_avs_address, `FANTC_IDX_HI_REMOTE2)) begin
			nxt_rdata = snap_remote2[9:2];
		end else if (sel(i_avs_address, `FANTC_IDX_LOCK)) begin
			nxt_rdata = {7'h00, lock_ff};
		end else if (sel(i_avs_address, `FANTC_IDX_INT_STATUS)) begin
			nxt_rdata = {5'h00, int_status_ff};
		end else if (sel(i_avs_address, `FANTC_IDX_INT_ENABLE)) begin
			nxt_rdata = {5'h00, int_enable_ff};
		end
	end

	// read data taken at capture so it stands through the ack cycle
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			rdata_ff <= 32'h00000000;
		end else if (capture && i_avs_read) begin
			rdata_ff <= {24'h000000, nxt_rdata};
		end
	end

	// write strobes; the low-bits and high-byte registers take no write
	// lock shuts config3 and the test pair, while pulse counts stay writable
	assign wr_config3 = wr_commit & ~lock_ff & sel(i_avs_address, `FANTC_IDX_CONFIG3); // R10
	assign wr_pulse_cnt = wr_commit & sel(i_avs_address, `FANTC_IDX_PULSE_CNT);
	assign wr_test1 = wr_commit & ~lock_ff & sel(i_avs_address, `FANTC_IDX_TEST_1); // R10
	assign wr_test2 = wr_commit & ~lock_ff & sel(i_avs_address, `FANTC_IDX_TEST_2); // R10
	assign wr_lock = wr_commit & sel(i_avs_address, `FANTC_IDX_LOCK) & wbyte[`FANTC_LOCK_BIT];
	assign wr_int_enable = wr_commit & sel(i_avs_address, `FANTC_IDX_INT_ENABLE);
	assign wr_int_clear = wr_commit & sel(i_avs_address, `FANTC_IDX_INT_CLEAR);

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			config3_ff <= `FANTC_CONFIG3_RST; // R9
		end else if (wr_config3) begin // R14
			config3_ff <= wbyte;
		end
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			pulse_cnt_ff <= `FANTC_PULSE_CNT_RST; // R12
		end else if (wr_pulse_cnt) begin
			pulse_cnt_ff <= wbyte; // R11
		end
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			test1_ff <= `FANTC_TEST_RST; // R13
		end else if (wr_test1) begin // R14
			test1_ff <= wbyte;
		end
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			test2_ff <= `FANTC_TEST_RST; // R13
		end else if (wr_test2) begin // R14
			test2_ff <= wbyte;
		end
	end

	// lock only sets; clearing it needs a reset, so a stray write cannot unlock
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			lock_ff <= 1'b0;
		end else if (wr_lock) begin
			lock_ff <= 1'b1; // R10
		end
	end
	assign o_lock = lock_ff;

	assign o_fast_mode = config3_ff[`FANTC_CFG3_FAST];
	assign o_continuous_tach = config3_ff[`FANTC_CFG3_CONT_LSB +: 4]; // R8

	// measurement period; a rate change restarts the count cleanly
	assign tick_last = config3_ff[`FANTC_CFG3_FAST] ? FAST_LAST : SLOW_LAST; // R7

	// tick is registered so status sees a clean one-cycle pulse
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			tick_cnt_ff <= 27'h0000000;
			tick_ff <= 1'b0;
			fast_prev_ff <= 1'b0;
		end else begin
			fast_prev_ff <= config3_ff[`FANTC_CFG3_FAST];
			tick_ff <= 1'b0;
			if (fast_prev_ff != config3_ff[`FANTC_CFG3_FAST]) begin
				tick_cnt_ff <= 27'h0000000;
			end else if (tick_cnt_ff >= tick_last) begin
				tick_cnt_ff <= 27'h0000000;
				tick_ff <= 1'b1; // R7
			end else begin
				tick_cnt_ff <= tick_cnt_ff + 27'h0000001;
			end
		end
	end
	assign o_measure_tick = tick_ff;

	// pulses-counted settings, registered per fan
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_fan
			reg [2:0] count_ff;
			always @(posedge i_clk) begin
				if (!i_rst_n) begin
					count_ff <= pulses(PULSE_CNT_RST[2*g +: 2]); // R12
				end else begin
					count_ff <= pulses(pulse_cnt_ff[2*g +: 2]); // R11 R12
				end
			end
			assign pulse_counts[3*g +: 3] = count_ff;
		end
	endgenerate
	assign o_pulse_count_fan_a = pulse_counts[2:0];
	assign o_pulse_count_fan_b = pulse_counts[5:3];
	assign o_pulse_count_fan_c = pulse_counts[8:6];
	assign o_pulse_count_fan_d = pulse_counts[11:9];

	// interrupt status: set wins over a clear in the same cycle
	assign int_events[`FANTC_INT_OUT_OF_LIMIT] = i_out_of_limit;
	assign int_events[`FANTC_INT_MEASURE_TICK] = tick_ff;
	assign int_events[`FANTC_INT_SNAP_RELEASE] = snap_release;
	assign int_clear = wr_int_clear ? wbyte[`FANTC_INT_WIDTH-1:0] : 3'h0;
	// clear is write-one; a bit written as zero keeps its state

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			int_status_ff <= 3'h0;
			int_enable_ff <= `FANTC_INT_ENABLE_RST;
		end else begin
			int_status_ff <= (int_status_ff & ~int_clear) | int_events;
			if (wr_int_enable) begin
				int_enable_ff <= wbyte[`FANTC_INT_WIDTH-1:0];
			end
		end
	end
	assign o_irq = |(int_status_ff & int_enable_ff);

	// shared pin: open-drain alert, or push-pull fan drive two
	assign alert_active = |(int_status_ff & int_enable_ff);
	assign o_shared_pin_out = config3_ff[`FANTC_CFG3_ALERT] ? 1'b0 : i_fan_drive_2; // R6
	assign o_shared_pin_oe_n = config3_ff[`FANTC_CFG3_ALERT] ? ~alert_active : 1'b0; // R6
endmodule // fantc_bank

// ---- fantc_regs.vh ----
// fantc register indices, field positions, reset values and timing counts
`ifndef FANTC_REGS_VH
`define FANTC_REGS_VH

// register indices; the byte address on the bus is four times the index
`define FANTC_IDX_LOW_BITS 8'h77
`define FANTC_IDX_CONFIG3 8'h78
`define FANTC_IDX_PULSE_CNT 8'h7B
`define FANTC_IDX_TEST_1 8'h7E
`define FANTC_IDX_TEST_2 8'h7F
`define FANTC_IDX_HI_12V 8'h80
`define FANTC_IDX_HI_REMOTE1 8'h81
`define FANTC_IDX_HI_LOCAL 8'h82
`define FANTC_IDX_HI_REMOTE2 8'h83
`define FANTC_IDX_LOCK 8'h84
`define FANTC_IDX_INT_STATUS 8'h85
`define FANTC_IDX_INT_ENABLE 8'h86
`define FANTC_IDX_INT_CLEAR 8'h87

// low-bits register: lsb position of each 2-bit field
`define FANTC_LOW_12V_LSB 0
`define FANTC_LOW_REMOTE1_LSB 2
`define FANTC_LOW_LOCAL_LSB 4
`define FANTC_LOW_REMOTE2_LSB 6

// tach_alert_config fields
`define FANTC_CFG3_ALERT 0
`define FANTC_CFG3_FAST 3
`define FANTC_CFG3_CONT_LSB 4

// lock register field
`define FANTC_LOCK_BIT 0

// interrupt status / enable / clear fields
`define FANTC_INT_OUT_OF_LIMIT 0
`define FANTC_INT_MEASURE_TICK 1
`define FANTC_INT_SNAP_RELEASE 2
`define FANTC_INT_WIDTH 3

// reset values
`define FANTC_CONFIG3_RST 8'h00
`define FANTC_PULSE_CNT_RST 8'h55
`define FANTC_TEST_RST 8'h00
`define FANTC_INT_ENABLE_RST 3'h0

// timing
`define FANTC_CLK_KHZ 125000
`define FANTC_SLOW_PERIOD_MS 1000
`define FANTC_FAST_PERIOD_MS 250

`endif

// ---- fantc_snap.v ----
// fantc coherent snapshot of the four 10-bit readings
`timescale 1ns/1ps

`include "fantc_regs.vh"

module fantc_snap (
	input wire i_clk,
	input wire i_rst_n,
	input wire [39:0] i_live,
	input wire i_low_read,
	input wire [3:0] i_hi_read,
	output wire [39:0] o_snap,
	output wire o_frozen,
	output wire o_release
);
	reg [3:0] pending_ff;
	reg [3:0] nxt_pending;
	reg release_ff;
	wire frozen;

	assign frozen = |pending_ff;
	assign o_frozen = frozen;
	assign o_release = release_ff;

	// each high-byte read clears its own pending bit; all channels stay frozen until all four are read
	always @* begin
		nxt_pending = pending_ff & ~i_hi_read; // R5
		if (i_low_read) begin
			nxt_pending = 4'hF; // R5
		end
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			pending_ff <= 4'h0;
			release_ff <= 1'b0;
		end else begin
			pending_ff <= nxt_pending;
			release_ff <= frozen & ~(|nxt_pending);
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_chan
			reg [9:0] snap_ff;
			always @(posedge i_clk) begin
				if (!i_rst_n) begin
					snap_ff <= 10'h000;
				end else if (!frozen && !i_low_read) begin
					snap_ff <= i_live[g*10 +: 10]; // R5
				end
			end
			assign o_snap[g*10 +: 10] = snap_ff;
		end
	endgenerate
endmodule // fantc_snap

// ---- fantc_monitor.sv ----
// fantc checker: config outputs, lock, pin, tick spacing and read data
`timescale 1ns/1ps
module fantc_monitor #(
	parameter SLOW_CYCLES = 40,
	parameter FAST_CYCLES = 10
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire [9:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	input wire [31:0] o_avs_readdata,
	input wire o_avs_waitrequest,
	input wire i_fan_drive_2,
	input wire o_shared_pin_out,
	input wire o_shared_pin_oe_n,
	input wire o_measure_tick,
	input wire o_fast_mode,
	input wire [3:0] o_continuous_tach,
	input wire [2:0] o_pulse_count_fan_a,
	input wire [2:0] o_pulse_count_fan_d,
	input wire o_lock,
	input wire o_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// commit edge of a low-byte write; pulse counts ignore the lock
	wire wr_go = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
	wire wr_ok = wr_go && !o_lock;
	a_cfg_outputs: assert property (wr_ok && i_avs_address == 10'h1E0 |=>
		o_fast_mode == $past(i_avs_writedata[3]) &&
		o_continuous_tach == $past(i_avs_writedata[7:4])) else $error("config outputs wrong");
	a_lock_freezes: assert property (o_lock |=> o_lock && $stable(o_fast_mode) &&
		$stable(o_continuous_tach)) else $error("locked config changed");
	a_pulse_map: assert property (wr_go && i_avs_address == 10'h1EC |=> ##1
		o_pulse_count_fan_a == {1'b0, $past(i_avs_writedata[1:0], 2)} + 3'h1 &&
		o_pulse_count_fan_d == {1'b0, $past(i_avs_writedata[7:6], 2)} + 3'h1)
		else $error("pulse count wrong");
	a_pin_fan_only: assert property (o_shared_pin_out |->
		i_fan_drive_2 && !o_shared_pin_oe_n) else $error("pin high outside fan mode");
	a_pin_irq_drive: assert property (o_irq |-> !o_shared_pin_oe_n)
		else $error("pin released while irq");
	a_tick_spacing: assert property (o_measure_tick |=> (!o_measure_tick) [*8])
		else $error("ticks too close");
	a_reset_values: assert property ($rose(i_rst_n) |-> !o_fast_mode && !o_lock &&
		o_continuous_tach == 4'h0 && o_pulse_count_fan_d == 3'h2) else $error("reset values");
	a_rdata_holds: assert property (!(i_avs_read && o_avs_waitrequest) |=>
		$stable(o_avs_readdata)) else $error("read data moved");
endmodule // fantc_monitor

bind fantc_bank fantc_monitor #(.SLOW_CYCLES(SLOW_CYCLES), .FAST_CYCLES(FAST_CYCLES)) u_mon (
	.i_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
	.i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_fan_drive_2, .o_shared_pin_out,
	.o_shared_pin_oe_n, .o_measure_tick, .o_fast_mode, .o_continuous_tach,
	.o_pulse_count_fan_a, .o_pulse_count_fan_d, .o_lock, .o_irq);

// ---- fantc_host.sv ----
// fantc host model: bus master issuing single register transfers
`timescale 1ns/1ps
module fantc_host (
	input wire i_clk,
	input wire i_wait,
	input wire [31:0] i_rdata,
	output logic [9:0] o_addr = 10'h000,
	output logic o_rd = 1'b0,
	output logic o_wr = 1'b0,
	output logic [31:0] o_wdata = 32'h0,
	output logic [3:0] o_be = 4'hF
);
	// request held until waitrequest is sampled low at a rising edge; no fixed latency
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge i_clk);
		o_addr <= {idx, 2'b00};
		o_wr <= w;
		o_rd <= !w;
		o_wdata <= {24'h0, d};
		do @(posedge i_clk); while (i_wait !== 1'b0);
		q = i_rdata[7:0];
		o_rd <= 1'b0;
		o_wr <= 1'b0;
	endtask
endmodule // fantc_host

// ---- test_fantc_bank.sv ----
// fantc bench: register sequences checked against expected values
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_fantc_bank;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic ool = 1'b0;
	logic fan = 1'b1;
	logic [9:0] meas [4] = '{10'h2A5, 10'h13E, 10'h0C7, 10'h35A};
	logic [9:0] old [4];
	logic [7:0] q;
	int fails = 0;
	int comparisons = 0;
	int n;
	wire [9:0] addr;
	wire [31:0] wdata, rdata;
	wire [3:0] be, cont;
	wire [2:0] pc [4];
	wire rd, wr, wt, pin, oe_n, tick, fast, lock, irq;
	always #4 i_clk = ~i_clk;
	fantc_host host (.i_clk(i_clk), .i_wait(wt), .i_rdata(rdata), .o_addr(addr), .o_rd(rd),
		.o_wr(wr), .o_wdata(wdata), .o_be(be));
	// short periods keep tick checks within a few hundred cycles
	fantc_bank #(.SLOW_CYCLES(40), .FAST_CYCLES(10)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wt),
		.i_meas_12v(meas[0]), .i_meas_remote1(meas[1]), .i_meas_local(meas[2]),
		.i_meas_remote2(meas[3]), .i_out_of_limit(ool), .i_fan_drive_2(fan),
		.o_shared_pin_out(pin), .o_shared_pin_oe_n(oe_n), .o_measure_tick(tick),
		.o_fast_mode(fast), .o_continuous_tach(cont), .o_pulse_count_fan_a(pc[0]),
		.o_pulse_count_fan_b(pc[1]), .o_pulse_count_fan_c(pc[2]), .o_pulse_count_fan_d(pc[3]),
		.o_lock(lock), .o_irq(irq));
	task automatic rd8(input logic [7:0] idx, input logic [7:0] exp);
		host.xfer(1'b0, idx, 8'h00, q);
		`CHK(q, exp)
	endtask
	task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
		host.xfer(1'b1, idx, d, q);
	endtask
	// negedges until the next tick, bounded
	task automatic gap(output int c);
		c = 0;
		do begin
			@(negedge i_clk);
			c++;
		end while (tick !== 1'b1 && c < 200);
	endtask
	task wrap_up;
		$display("compared %0d, mismatched %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		wrap_up;
	end
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd8(8'h78, 8'h00);
		rd8(8'h7B, 8'h55);
		rd8(8'h7E, 8'h00);
		rd8(8'h7F, 8'h00);
		`CHK({pc[0], pc[3], pin, oe_n}, 8'h4A)
		fan <= 1'b0;
		@(negedge i_clk);
		`CHK({pin, oe_n}, 2'b00)
		@(posedge i_clk) fan <= 1'b1;
		$display("reset test done");
		rd8(8'h77, {meas[3][1:0], meas[2][1:0], meas[1][1:0], meas[0][1:0]});
		old = meas;
		meas <= '{10'h001, 10'h3FE, 10'h155, 10'h2AA};
		wr8(8'h77, 8'hFF);
		rd8(8'h77, {old[3][1:0], old[2][1:0], old[1][1:0], old[0][1:0]});
		for (int k = 0; k < 4; k++) rd8(8'(8'h80 + k), old[k][9:2]);
		rd8(8'h80, meas[0][9:2]);
		$display("freeze test done");
		for (int k = 0; k < 4; k++) begin
			wr8(8'h7B, {2'(k + 3), 2'(k + 2), 2'(k + 1), 2'(k)});
			repeat (2) @(posedge i_clk);
			for (int f = 0; f < 4; f++) `CHK(pc[f], 3'((k + f) % 4 + 1))
		end
		$display("pulse test done");
		wr8(8'h78, 8'hF8);
		rd8(8'h78, 8'hF8);
		`CHK({fast, cont}, 5'h1F)
		gap(n);
		gap(n);
		`CHK(n, 10)
		wr8(8'h78, 8'h00);
		gap(n);
		gap(n);
		`CHK(n, 40)
		$display("tach test done");
		wr8(8'h78, 8'h01);
		wr8(8'h86, 8'h01);
		@(posedge i_clk) ool <= 1'b1;
		@(posedge i_clk) ool <= 1'b0;
		@(negedge i_clk);
		`CHK({irq, oe_n, pin}, 3'b100)
		wr8(8'h87, 8'h01);
		@(negedge i_clk);
		`CHK({irq, oe_n}, 2'b01)
		$display("alert test done");
		wr8(8'h7E, 8'hA5);
		wr8(8'h84, 8'h01);
		wr8(8'h78, 8'hFF);
		wr8(8'h7E, 8'h00);
		rd8(8'h78, 8'h01);
		rd8(8'h7E, 8'hA5);
		rd8(8'h84, 8'h01);
		wr8(8'h7B, 8'hE4);
		rd8(8'h7B, 8'hE4);
		rd8(8'h85, 8'h06);
		rd8(8'h90, 8'h00);
		$display("lock test done");
		wrap_up;
	end
endmodule // test_fantc_bank
